// *** nvm_access_defines.svh ***
`ifndef NVM_ACCESS_DEFINES_SVH
`define NVM_ACCESS_DEFINES_SVH

// register byte addresses on the wishbone bus
`define OFS_ADDR_LOW     8'h00
`define OFS_ADDR_HIGH    8'h04
`define OFS_DATA_LOW     8'h08
`define OFS_DATA_HIGH    8'h0C
`define OFS_CONTROL      8'h10
`define OFS_UNLOCK       8'h14
`define OFS_FLAGS_TWO    8'h18

// control register fields
`define CTL_SELECT_BIT   7
`define CTL_ERROR_BIT    3
`define CTL_ENABLE_BIT   2
`define CTL_WRITE_BIT    1
`define CTL_READ_BIT     0

// peripheral flags two field
`define FLAG_WCOMP_BIT   4

// unlock key values
`define UNLOCK_KEY_ONE   8'h55
`define UNLOCK_KEY_TWO   8'hAA

// widths
`define ADDR_HIGH_W      5
`define DATA_HIGH_W      6
`define PM_ADDR_W        13
`define PM_DATA_W        14
`define TIMER_W          16

// program read: word latched on the second cycle after the start
`define PREAD_LAST       2'h1

// write time
`define CLK_MHZ          10
`define WRITE_TIME_US    4000
`define WRITE_CYCLES     (`WRITE_TIME_US * `CLK_MHZ)

`endif

// *** nvm_access_pkg.sv ***
package nvm_access_pkg;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PREAD,
        OP_WRITE
    } op_t;

    typedef struct packed {
        logic [7:0]  addr_lo;
        logic [4:0]  addr_hi;
        logic [7:0]  data_lo;
        logic [5:0]  data_hi;
        logic        sel;
        logic        write_enable;
        logic        werr;
        logic        rd;
        logic        wr;
        logic        wcomp;
        logic [1:0]  unlock;
        op_t         op;
        logic [15:0] timer;
        logic [1:0]  pcnt;
        logic        ack;
        logic [7:0]  rdat;
        logic        ee_we;
        logic        pm_we;
        logic        pm_erase;
        logic        master_clear_reset_s1;
        logic        master_clear_reset_s2;
        logic        wdt_s1;
        logic        wdt_s2;
    } state_t;

endpackage

// *** nonvolatile_memory_access.sv ***
`timescale 1ns/1ps
`include "nvm_access_defines.svh"

// Operation
// RULE_01 - data memory uses only the low address and low data registers
// RULE_02 - data memory spans 256 bytes addressed 00h to FFh
// RULE_03 - data write duration comes from an internal timer; completion at expiry
// RULE_04 - a program write erases the location automatically before storing
// RULE_05 - program access uses 14-bit data word and 13-bit word address
// RULE_06 - program memory holds up to 8K words
// RULE_07 - software puts address high byte in high register, low in low
// RULE_08 - on small parts software keeps unused address bits clear
// RULE_09 - unlock register stores nothing and reads as zero
// RULE_10 - memory select steers accesses: clear data, set program
// RULE_11 - read and write start bits set only; hardware clears on completion
// RULE_12 - writes allowed only while write enable is one; zero after power-up
// RULE_13 - master clear or watchdog reset during a write sets the error flag
// RULE_14 - such a reset keeps address, data and memory select
// RULE_15 - write completion sets the completion flag; only software clears it
// RULE_16 - write starts only after 55h, AAh to unlock, then start bit
// RULE_17 - start refused unless enable already set; clearing enable later is harmless
// RULE_18 - data read loads low data register next cycle and holds it
// RULE_19 - program read latches word on second cycle, readable from the third
// RULE_20 - an uninterrupted write completion clears the error flag
module nonvolatile_memory_access
    import nvm_access_pkg::*;
#(
    parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    master_clear_reset_n_i,
    input  wire logic                    watchdog_reset_i,
    output logic      [7:0]              ee_addr_o,
    output logic      [7:0]              ee_wdata_o,
    output logic                         ee_we_o,
    input  wire logic [7:0]              ee_rdata_i,
    output logic      [`PM_ADDR_W-1:0]   pm_addr_o,
    output logic      [`PM_DATA_W-1:0]   pm_wdata_o,
    output logic                         pm_erase_o,
    output logic                         pm_we_o,
    input  wire logic [`PM_DATA_W-1:0]   pm_rdata_i,
    output logic                         write_complete_flag_o
);

    state_t s_ff;
    state_t nxt_s;

    function automatic logic [7:0] read_mux(input state_t st, input logic [7:0] adr);
        logic [7:0] v;
        v = 8'h00;
        case (adr)
            `OFS_ADDR_LOW:  v = st.addr_lo;
            `OFS_ADDR_HIGH: v = {3'h0, st.addr_hi};
            `OFS_DATA_LOW:  v = st.data_lo;
            `OFS_DATA_HIGH: v = {2'h0, st.data_hi};
            `OFS_CONTROL: begin
                v[`CTL_SELECT_BIT] = st.sel;
                v[`CTL_ERROR_BIT]  = st.werr;
                v[`CTL_ENABLE_BIT] = st.write_enable;
                v[`CTL_WRITE_BIT]  = st.wr;
                v[`CTL_READ_BIT]   = st.rd;
            end
            `OFS_UNLOCK:    v = 8'h00; // RULE_09
            `OFS_FLAGS_TWO: v[`FLAG_WCOMP_BIT] = st.wcomp;
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    logic       bus_req;
    logic       bus_wr;
    logic       busy;
    logic       ext_rst;
    logic [7:0] wd;

    always_comb begin
        nxt_s = s_ff;
        bus_req = wb_cyc_i & wb_stb_i & ~s_ff.ack;
        bus_wr = bus_req & wb_we_i & wb_sel_i[0];
        busy = (s_ff.op != OP_IDLE) | s_ff.rd;
        ext_rst = s_ff.master_clear_reset_s2 | s_ff.wdt_s2;
        wd = wb_dat_i[7:0];

        nxt_s.master_clear_reset_s1 = ~master_clear_reset_n_i;
        nxt_s.master_clear_reset_s2 = s_ff.master_clear_reset_s1;
        nxt_s.wdt_s1 = watchdog_reset_i;
        nxt_s.wdt_s2 = s_ff.wdt_s1;

        nxt_s.ack = bus_req;
        nxt_s.rdat = 8'h00;
        nxt_s.ee_we = 1'b0;
        nxt_s.pm_we = 1'b0;
        nxt_s.pm_erase = 1'b0;

        if (bus_req && !wb_we_i) begin
            nxt_s.rdat = read_mux(s_ff, wb_adr_i);
        end

        if (bus_wr) begin
            // any byte-lane-0 write other than the next expected key breaks the sequence
            nxt_s.unlock = 2'h0; // RULE_16
            case (wb_adr_i)
                `OFS_ADDR_LOW: begin
                    if (!busy) begin
                        nxt_s.addr_lo = wd; // RULE_07
                    end
                end
                `OFS_ADDR_HIGH: begin
                    if (!busy) begin
                        nxt_s.addr_hi = wd[`ADDR_HIGH_W-1:0]; // RULE_07
                    end
                end
                `OFS_DATA_LOW: begin
                    if (!busy) begin
                        nxt_s.data_lo = wd;
                    end
                end
                `OFS_DATA_HIGH: begin
                    if (!busy) begin
                        nxt_s.data_hi = wd[`DATA_HIGH_W-1:0];
                    end
                end
                `OFS_CONTROL: begin
                    nxt_s.write_enable = wd[`CTL_ENABLE_BIT];
                    nxt_s.werr = wd[`CTL_ERROR_BIT];
                    if (!busy) begin
                        nxt_s.sel = wd[`CTL_SELECT_BIT]; // RULE_10
                        if (wd[`CTL_READ_BIT]) begin
                            nxt_s.rd = 1'b1; // RULE_11
                            if (nxt_s.sel) begin
                                nxt_s.op = OP_PREAD; // RULE_19
                                nxt_s.pcnt = 2'h0;
                            end
                        end else if (wd[`CTL_WRITE_BIT] && s_ff.write_enable
                                     && s_ff.unlock == 2'h2) begin // RULE_12 RULE_16 RULE_17
                            nxt_s.wr = 1'b1; // RULE_11
                            nxt_s.op = OP_WRITE;
                            nxt_s.timer = 16'(WRITE_CYCLES - 1); // RULE_03
                            nxt_s.pm_erase = nxt_s.sel; // RULE_04
                        end
                    end
                end
                `OFS_UNLOCK: begin
                    if (wd == `UNLOCK_KEY_ONE) begin
                        nxt_s.unlock = 2'h1; // RULE_16
                    end else if (wd == `UNLOCK_KEY_TWO && s_ff.unlock == 2'h1) begin
                        nxt_s.unlock = 2'h2; // RULE_16
                    end
                end
                `OFS_FLAGS_TWO: nxt_s.wcomp = wd[`FLAG_WCOMP_BIT]; // RULE_15
                default: nxt_s.unlock = 2'h0;
            endcase
        end

        case (s_ff.op)
            OP_IDLE: begin
                if (s_ff.rd && !s_ff.sel) begin
                    nxt_s.data_lo = ee_rdata_i; // RULE_01 RULE_02 RULE_18
                    nxt_s.rd = 1'b0; // RULE_11
                end
            end
            OP_PREAD: begin
                if (s_ff.pcnt == `PREAD_LAST) begin
                    nxt_s.data_lo = pm_rdata_i[7:0]; // RULE_05 RULE_06 RULE_19
                    nxt_s.data_hi = pm_rdata_i[`PM_DATA_W-1:8];
                    nxt_s.rd = 1'b0;
                    nxt_s.op = OP_IDLE;
                end else begin
                    nxt_s.pcnt = s_ff.pcnt + 2'h1;
                end
            end
            OP_WRITE: begin
                if (s_ff.timer == 16'h0000) begin
                    nxt_s.ee_we = ~s_ff.sel; // RULE_01 RULE_03
                    nxt_s.pm_we = s_ff.sel; // RULE_05
                    nxt_s.wr = 1'b0; // RULE_11
                    nxt_s.werr = 1'b0; // RULE_20
                    nxt_s.wcomp = 1'b1; // RULE_15
                    nxt_s.op = OP_IDLE;
                end else begin
                    nxt_s.timer = s_ff.timer - 16'h0001; // RULE_03
                end
            end
            default: nxt_s.op = OP_IDLE;
        endcase

        if (ext_rst) begin
            // address, data and select survive for a retry
            nxt_s.werr = (s_ff.op == OP_WRITE) ? 1'b1 : s_ff.werr; // RULE_13 RULE_14
            nxt_s.addr_lo = s_ff.addr_lo; // RULE_14
            nxt_s.addr_hi = s_ff.addr_hi;
            nxt_s.data_lo = s_ff.data_lo;
            nxt_s.data_hi = s_ff.data_hi;
            nxt_s.sel = s_ff.sel;
            nxt_s.wcomp = s_ff.wcomp;
            nxt_s.write_enable = 1'b0;
            nxt_s.rd = 1'b0;
            nxt_s.wr = 1'b0;
            nxt_s.unlock = 2'h0;
            nxt_s.op = OP_IDLE;
            nxt_s.timer = 16'h0000;
            nxt_s.pcnt = 2'h0;
            nxt_s.ack = 1'b0;
            nxt_s.rdat = 8'h00;
            nxt_s.ee_we = 1'b0;
            nxt_s.pm_we = 1'b0;
            nxt_s.pm_erase = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0; // RULE_12
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_dat_o = {24'h000000, s_ff.rdat};
    assign wb_ack_o = s_ff.ack;
    assign ee_addr_o = s_ff.addr_lo;
    assign ee_wdata_o = s_ff.data_lo;
    assign ee_we_o = s_ff.ee_we;
    assign pm_addr_o = {s_ff.addr_hi, s_ff.addr_lo};
    assign pm_wdata_o = {s_ff.data_hi, s_ff.data_lo};
    assign pm_erase_o = s_ff.pm_erase;
    assign pm_we_o = s_ff.pm_we;
    assign write_complete_flag_o = s_ff.wcomp;

endmodule

// *** nvm_access_asserts.sv ***
`timescale 1ns/1ps
`include "nvm_access_defines.svh"
module nvm_access_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        master_clear_reset_n_i,
    input wire logic        watchdog_reset_i,
    input wire logic [7:0]  ee_addr_o,
    input wire logic        ee_we_o,
    input wire logic [12:0] pm_addr_o,
    input wire logic [13:0] pm_wdata_o,
    input wire logic        pm_erase_o,
    input wire logic        pm_we_o,
    input wire logic        write_complete_flag_o
);
    logic clr_w;
    logic hold_w;
    assign clr_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `OFS_FLAGS_TWO;
    assign hold_w = !master_clear_reset_n_i || watchdog_reset_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence unl_rd_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `OFS_UNLOCK;
    endsequence
    sequence stored_s;
        ee_we_o || pm_we_o;
    endsequence
    addr_tie_a: assert property (ee_addr_o == pm_addr_o[7:0])
        else $error("data address not the low address");
    hi_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    unlock_zero_a: assert property (unl_rd_s |=> wb_dat_o == 32'h0)
        else $error("unlock read not zero");
    flag_set_a: assert property (stored_s |-> ##[0:1] write_complete_flag_o)
        else $error("completion flag not set");
    flag_hold_a: assert property ($fell(write_complete_flag_o) |->
        $past(clr_w) || $past(clr_w, 2))
        else $error("completion flag cleared by hardware");
    erase_first_a: assert property (pm_erase_o |->
        (!ee_we_o && !pm_we_o) ##1 !pm_erase_o)
        else $error("erase pulse malformed");
    abort_store_a: assert property (hold_w [*4] |-> !ee_we_o && !pm_we_o)
        else $error("store during reset");
    // pins reach the logic through two flops, so look two samples back
    keep_regs_a: assert property ($past(hold_w, 2) |=>
        $stable(pm_addr_o) && $stable(pm_wdata_o))
        else $error("address or data lost in reset");
endmodule

bind nonvolatile_memory_access nvm_access_asserts chk_u (.*);

// *** nonvolatile_memory_access_tb_top.sv ***
`timescale 1ns/1ps
`include "nvm_access_defines.svh"
module nonvolatile_memory_access_tb_top;
    localparam int WCYC = 20;
    logic        clk, rst, cyc, stb, we, master_clear_reset_n, wdt, ack, eewe, pme, pmwe, flag, erased;
    logic [7:0]  adr, eea, eew;
    logic [31:0] dw, dr, rdv;
    logic [3:0]  sel;
    logic [12:0] pma;
    logic [13:0] pmw;
    logic [7:0]  ee_mem [256];
    logic [13:0] pm_mem [8192];
    int          err_total, num_checks, n;
    nonvolatile_memory_access #(.WRITE_CYCLES(WCYC)) dut_u (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_ack_o(ack), .master_clear_reset_n_i(master_clear_reset_n),
        .watchdog_reset_i(wdt), .ee_addr_o(eea), .ee_wdata_o(eew),
        .ee_we_o(eewe), .ee_rdata_i(ee_mem[eea]), .pm_addr_o(pma),
        .pm_wdata_o(pmw), .pm_erase_o(pme), .pm_we_o(pmwe),
        .pm_rdata_i(pm_mem[pma]), .write_complete_flag_o(flag));
    // memory arrays behind the block
    always @(posedge clk) begin
        if (eewe) ee_mem[eea] <= eew;
        if (pme) begin
            pm_mem[pma] <= 14'h3FFF;
            erased <= 1'b1;
        end
        if (pmwe) pm_mem[pma] <= pmw;
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdv = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h00);
        chk(rdv, e);
    endtask
    task automatic go(input logic [7:0] k2, input logic [7:0] c);
        wr(`OFS_UNLOCK, 8'h55);
        wr(`OFS_UNLOCK, k2);
        wr(`OFS_CONTROL, c);
    endtask
    task automatic wflag();
        n = 0;
        while (flag !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        // let the memory model take the store pulse before anyone looks
        @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #3000000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {cyc, stb, we, wdt, erased, adr, dw} = '0;
        {rst, master_clear_reset_n, sel} = 6'h3F;
        ee_mem[8'hFF] = 8'h5A;
        ee_mem[8'h10] = 8'h00;
        ee_mem[8'h34] = 8'h00;
        pm_mem[13'h1534] = 14'h2ABC;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_CONTROL, 32'h0);
        wr(`OFS_UNLOCK, 8'h5A);
        rd(`OFS_UNLOCK, 32'h0);
        rd(`OFS_FLAGS_TWO, 32'h0);
        wr(`OFS_ADDR_HIGH, 8'h1F);
        wr(`OFS_ADDR_LOW, 8'hFF);
        wr(`OFS_CONTROL, 8'h01);
        rd(`OFS_DATA_LOW, 32'h5A);
        rd(`OFS_CONTROL, 32'h0);
        wr(`OFS_DATA_LOW, 8'h3C);
        sel <= 4'hE;
        wr(`OFS_DATA_LOW, 8'hEE);
        sel <= 4'hF;
        rd(`OFS_DATA_LOW, 32'h3C);
        go(8'hAA, 8'h06);
        go(8'h5A, 8'h06);
        repeat (WCYC + 5) @(posedge clk);
        chk(ee_mem[8'hFF], 8'h5A);
        chk(flag, 1'b0);
        go(8'hAA, 8'h02);
        wflag();
        chk(n, WCYC - 1);
        chk(ee_mem[8'hFF], 8'h3C);
        rd(`OFS_CONTROL, 32'h0);
        repeat (5) @(posedge clk);
        rd(`OFS_FLAGS_TWO, 32'h10);
        wr(`OFS_FLAGS_TWO, 8'h00);
        rd(`OFS_FLAGS_TWO, 32'h0);
        wr(`OFS_ADDR_HIGH, 8'h15);
        wr(`OFS_ADDR_LOW, 8'h34);
        wr(`OFS_CONTROL, 8'h81);
        rd(`OFS_DATA_LOW, 32'hBC);
        rd(`OFS_DATA_HIGH, 32'h2A);
        wr(`OFS_DATA_LOW, 8'h11);
        wr(`OFS_DATA_HIGH, 8'h3F);
        wr(`OFS_CONTROL, 8'h84);
        go(8'hAA, 8'h86);
        wr(`OFS_CONTROL, 8'h84);
        rd(`OFS_CONTROL, 32'h86);
        wflag();
        chk(erased, 1'b1);
        chk(pm_mem[13'h1534], 14'h3F11);
        chk(ee_mem[8'h34], 8'h00);
        wr(`OFS_FLAGS_TWO, 8'h00);
        // first pass master clear, second pass watchdog
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_CONTROL, 8'h04);
            wr(`OFS_ADDR_LOW, 8'h10);
            wr(`OFS_DATA_LOW, 8'h77 + 8'(i));
            go(8'hAA, 8'h06);
            repeat (4) @(posedge clk);
            master_clear_reset_n <= i[0];
            wdt <= i[0];
            repeat (6) @(posedge clk);
            master_clear_reset_n <= 1'b1;
            wdt <= 1'b0;
            repeat (4) @(posedge clk);
            chk(ee_mem[8'h10], 8'h00);
            rd(`OFS_CONTROL, 32'h08);
            rd(`OFS_ADDR_LOW, 32'h10);
            rd(`OFS_DATA_LOW, 32'h77 + i);
        end
        // retry the aborted store with the error bit still set
        wr(`OFS_CONTROL, 8'h0C);
        go(8'hAA, 8'h0E);
        wflag();
        chk(ee_mem[8'h10], 8'h78);
        rd(`OFS_CONTROL, 32'h04);
        report_and_stop();
    end
endmodule
